// ### verilog/cct_timer_defs.vh
// register indices, field positions, reset values and clock codes of the compare timer
`ifndef CCT_TIMER_DEFS_VH
`define CCT_TIMER_DEFS_VH

// register indices; byte address on the bus is four times the index
`define CCT_ADDR_W 18
`define CCT_IDX_W 16
`define CCT_IDX_CTRL 16'hffb6
`define CCT_IDX_STAT 16'hffb7
`define CCT_IDX_CNTH 16'hffb8
`define CCT_IDX_CNTL 16'hffb9
`define CCT_IDX_CMPH 16'hffba
`define CCT_IDX_CMPL 16'hffbb
`define CCT_IDX_IRQ 16'hffbc
`define CCT_IDX_CKSTP 16'hfffa

// control_reg fields
`define CCT_CTRL_HI_TOGGLE_LEVEL 7
`define CCT_CTRL_HSEL_MSB 6
`define CCT_CTRL_HSEL_LSB 4
`define CCT_CTRL_LO_TOGGLE_LEVEL 3
`define CCT_CTRL_LSEL_MSB 2
`define CCT_CTRL_LSEL_LSB 0

// ctl_status_reg fields, channel n (0 lower, 1 upper) sits at 4*n
`define CCT_STAT_OVF 3
`define CCT_STAT_CMF 2
`define CCT_STAT_OVIE 1
`define CCT_STAT_CCLR 0

// irq_enable_reg / irq_request_reg / edge select, gathered in one register
`define CCT_IRQ_EDGE 0
`define CCT_IRQ_ENL 1
`define CCT_IRQ_ENH 2
`define CCT_IRQ_REQL 4
`define CCT_IRQ_REQH 5

// module standby bit in clock_stop_reg, 0 parks the timer
`define CCT_CKSTP_RUN 1

// reset values
`define CCT_RST_CTRL 8'h00
`define CCT_RST_STAT 8'h00
`define CCT_RST_CNT 8'h00
`define CCT_RST_CMP 8'hff
`define CCT_RST_IRQ 8'h00
`define CCT_RST_CKSTP 8'hff

// clock select codes
`define CCT_SEL_CASCADE 3'h0
`define CCT_SEL_EVENT 3'h0
`define CCT_SEL_SYS32 3'h4
`define CCT_SEL_SYS16 3'h5
`define CCT_SEL_SYS4 3'h6
`define CCT_SEL_WATCH4 3'h7

// prescaler division counts
`define CCT_SYS_DIV_W 5
`define CCT_SYS_DIV32 5'h1f
`define CCT_SYS_DIV16 4'hf
`define CCT_SYS_DIV4 2'h3
`define CCT_WATCH_DIV4 2'h3

`endif

// ### verilog/cct_prescaler.v
// prescaler taps: system clock /32 /16 /4 and watch clock /4 as one-cycle ticks
`timescale 1ns/1ps
`include "cct_timer_defs.vh"

module cct_prescaler (
  input wire ref_clk,
  input wire rst,
  input wire watchClk,
  output reg tick32,
  output reg tick16,
  output reg tick4,
  output reg tickW4
);

  reg [`CCT_SYS_DIV_W-1:0] sysCnt_q;
  reg watchPrev_q;
  reg [1:0] watchCnt_q;
  wire watchRise;

  assign watchRise = watchClk & ~watchPrev_q;

  // free-running divider; taps stay aligned so a source switch never double-counts
  always @(posedge ref_clk) begin
    if (rst) begin
      sysCnt_q <= {`CCT_SYS_DIV_W{1'b0}};
      tick32 <= 1'b0;
      tick16 <= 1'b0;
      tick4 <= 1'b0;
    end else begin
      sysCnt_q <= sysCnt_q + 5'h01;
      tick32 <= (sysCnt_q == `CCT_SYS_DIV32);
      tick16 <= (sysCnt_q[3:0] == `CCT_SYS_DIV16);
      tick4 <= (sysCnt_q[1:0] == `CCT_SYS_DIV4);
    end
  end

  // watch clock is slow and sampled here; error of one ref_clk period at most
  always @(posedge ref_clk) begin
    if (rst) begin
      watchPrev_q <= 1'b0;
      watchCnt_q <= 2'h0;
      tickW4 <= 1'b0;
    end else begin
      watchPrev_q <= watchClk;
      tickW4 <= 1'b0;
      if (watchRise) begin
        watchCnt_q <= watchCnt_q + 2'h1;
        tickW4 <= (watchCnt_q == `CCT_WATCH_DIV4);
      end
    end
  end

endmodule // cct_prescaler

// ### verilog/cct_timer.v
// cascadable compare timer: two 8-bit or one 16-bit up-counter behind an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "cct_timer_defs.vh"

module cct_timer (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CCT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire eventIn,
  input wire watchClk,
  input wire subClockMode,
  output reg hiToggleOut,
  output reg loToggleOut,
  output reg hiIrqCpu,
  output reg loIrqCpu
);

  // register state
  reg [7:0] ctrl_q;
  reg [7:0] status_q;
  reg [7:0] irqReg_q;
  reg [7:0] clkStop_q;
  reg [7:0] countHi_q;
  reg [7:0] countLo_q;
  reg [7:0] matchHi_q;
  reg [7:0] matchLo_q;
  reg [7:0] holdLatch_q;
  reg [1:0] armOvf_q;
  reg [1:0] armCmf_q;
  reg eventPrev_q;

  // prescaler taps
  wire tick32, tick16, tick4, tickW4;

  cct_prescaler uPrescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .watchClk(watchClk),
    .tick32(tick32),
    .tick16(tick16),
    .tick4(tick4),
    .tickW4(tickW4)
  );

  // mode and select decode
  wire [2:0] hiSel = ctrl_q[`CCT_CTRL_HSEL_MSB:`CCT_CTRL_HSEL_LSB];
  wire [2:0] loSel = ctrl_q[`CCT_CTRL_LSEL_MSB:`CCT_CTRL_LSEL_LSB];
  wire mode16 = ~hiSel[2];
  wire running = clkStop_q[`CCT_CKSTP_RUN];

  // internal source pick; prohibited codes give no tick
  function selTick;
    input [2:0] sel;
    input t32;
    input t16;
    input t4;
    input tw;
    input sub;
    begin
      case (sel)
        `CCT_SEL_SYS32: selTick = t32 & ~sub;
        `CCT_SEL_SYS16: selTick = t16 & ~sub;
        `CCT_SEL_SYS4: selTick = t4 & ~sub;
        `CCT_SEL_WATCH4: selTick = tw;
        default: selTick = 1'b0;
      endcase
    end
  endfunction

  // external edge, chosen edge polarity; lower counter only
  wire eventEdge = irqReg_q[`CCT_IRQ_EDGE] ? (eventPrev_q & ~eventIn) :
                   (~eventPrev_q & eventIn);

  wire loTick = running & ((loSel == `CCT_SEL_EVENT) ? (eventEdge & ~subClockMode) :
                selTick(loSel, tick32, tick16, tick4, tickW4, subClockMode));
  wire hiTick8 = running & ~mode16 &
                 selTick(hiSel, tick32, tick16, tick4, tickW4, subClockMode);

  // 16-bit path: lower byte counts, upper byte takes its carry
  wire [15:0] wideCount = {countHi_q, countLo_q};
  wire [15:0] wideMatchValue = {matchHi_q, matchLo_q};
  wire wideTick = mode16 & loTick;
  wire wideAtMatch = (wideCount == wideMatchValue);
  wire wideClr = status_q[4 + `CCT_STAT_CCLR] & wideAtMatch;
  wire loCarry = (countLo_q == 8'hff);
  wire [15:0] wideNext = wideClr ? 16'h0000 :
                         {countHi_q + {7'h00, loCarry}, countLo_q + 8'h01};
  wire wideOvf = wideTick & ~wideClr & (wideCount == 16'hffff);
  wire wideMatch = wideTick & (wideNext == wideMatchValue);

  // 8-bit paths
  wire loTick8 = ~mode16 & loTick;
  wire hiClr8 = status_q[4 + `CCT_STAT_CCLR] & (countHi_q == matchHi_q);
  wire loClr8 = status_q[`CCT_STAT_CCLR] & (countLo_q == matchLo_q);
  wire [7:0] hiNext8 = hiClr8 ? 8'h00 : countHi_q + 8'h01;
  wire [7:0] loNext8 = loClr8 ? 8'h00 : countLo_q + 8'h01;

  // events per channel, index 1 upper, 0 lower
  wire [1:0] ovfEv;
  wire [1:0] matchEv;
  assign ovfEv[1] = mode16 ? wideOvf : (hiTick8 & ~hiClr8 & (countHi_q == 8'hff));
  assign ovfEv[0] = loTick8 & ~loClr8 & (countLo_q == 8'hff);
  assign matchEv[1] = mode16 ? wideMatch : (hiTick8 & (hiNext8 == matchHi_q));
  assign matchEv[0] = loTick8 & (loNext8 == matchLo_q);

  // APB phases and decode
  wire [`CCT_IDX_W-1:0] addrIdx = paddr[`CCT_ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire selCtrl = aligned & (addrIdx == `CCT_IDX_CTRL);
  wire selStat = aligned & (addrIdx == `CCT_IDX_STAT);
  wire selCntH = aligned & (addrIdx == `CCT_IDX_CNTH);
  wire selCntL = aligned & (addrIdx == `CCT_IDX_CNTL);
  wire selCmpH = aligned & (addrIdx == `CCT_IDX_CMPH);
  wire selCmpL = aligned & (addrIdx == `CCT_IDX_CMPL);
  wire selIrq = aligned & (addrIdx == `CCT_IDX_IRQ);
  wire selCkstp = aligned & (addrIdx == `CCT_IDX_CKSTP);
  wire mapped = selCtrl | selStat | selCntH | selCntL | selCmpH | selCmpL | selIrq | selCkstp;
  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable & pready;
  wire wrEn = accessPh & pwrite & mapped;
  wire rdSetup = setupPh & ~pwrite & mapped;
  wire [7:0] wrByte = pwdata[7:0];

  // read mux; control reads back zero since it is write-only
  reg [7:0] rdByte;
  always @* begin
    rdByte = 8'h00;
    if (selStat) begin
      rdByte = status_q;
    end else if (selCntH) begin
      rdByte = countHi_q;
    end else if (selCntL) begin
      rdByte = mode16 ? holdLatch_q : countLo_q;
    end else if (selCmpH) begin
      rdByte = matchHi_q;
    end else if (selCmpL) begin
      rdByte = mode16 ? holdLatch_q : matchLo_q;
    end else if (selIrq) begin
      rdByte = irqReg_q;
    end else if (selCkstp) begin
      rdByte = clkStop_q;
    end
  end

  // bus answer: data captured in setup so pready is already high in access
  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh & ~mapped;
      if (setupPh) begin
        prdata <= {24'h000000, rdByte};
      end
    end
  end

  // control and clock stop registers; no hardware writer, control is write-only
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `CCT_RST_CTRL;
      clkStop_q <= `CCT_RST_CKSTP;
    end else begin
      if (wrEn & selCtrl) begin
        ctrl_q <= wrByte;
      end
      if (wrEn & selCkstp) begin
        clkStop_q <= wrByte;
      end
    end
  end

  // holding latch: filled by upper read in setup or upper write in access
  always @(posedge ref_clk) begin
    if (rst) begin
      holdLatch_q <= 8'h00;
    end else if (mode16) begin
      if (wrEn & (selCntH | selCmpH)) begin
        holdLatch_q <= wrByte;
      end else if (rdSetup & selCntH) begin
        holdLatch_q <= countLo_q;
      end else if (rdSetup & selCmpH) begin
        holdLatch_q <= matchLo_q;
      end
    end
  end

  // counters: a CPU write beats a tick in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      countHi_q <= `CCT_RST_CNT;
      countLo_q <= `CCT_RST_CNT;
    end else if (mode16) begin
      if (wrEn & selCntL) begin
        countHi_q <= holdLatch_q;
        countLo_q <= wrByte;
      end else if (wideTick) begin
        countHi_q <= wideNext[15:8];
        countLo_q <= wideNext[7:0];
      end
    end else begin
      if (wrEn & selCntH) begin
        countHi_q <= wrByte;
      end else if (hiTick8) begin
        countHi_q <= hiNext8;
      end
      if (wrEn & selCntL) begin
        countLo_q <= wrByte;
      end else if (loTick8) begin
        countLo_q <= loNext8;
      end
    end
  end

  // compare bytes; 16-bit writes commit both halves on the lower write
  always @(posedge ref_clk) begin
    if (rst) begin
      matchHi_q <= `CCT_RST_CMP;
      matchLo_q <= `CCT_RST_CMP;
    end else if (mode16) begin
      if (wrEn & selCmpL) begin
        matchHi_q <= holdLatch_q;
        matchLo_q <= wrByte;
      end
    end else begin
      if (wrEn & selCmpH) begin
        matchHi_q <= wrByte;
      end
      if (wrEn & selCmpL) begin
        matchLo_q <= wrByte;
      end
    end
  end

  // per-channel status bits; hardware set wins over a software clear
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : gChan
      wire wrStat;
      wire clrOvf;
      wire clrCmf;
      assign wrStat = wrEn & selStat;
      assign clrOvf = wrStat & ~wrByte[4*ch + `CCT_STAT_OVF] & armOvf_q[ch];
      assign clrCmf = wrStat & ~wrByte[4*ch + `CCT_STAT_CMF] & armCmf_q[ch];
      always @(posedge ref_clk) begin
        if (rst) begin
          status_q[4*ch+3:4*ch] <= 4'h0;
          armOvf_q[ch] <= 1'b0;
          armCmf_q[ch] <= 1'b0;
        end else begin
          status_q[4*ch + `CCT_STAT_OVF] <= ovfEv[ch] |
            (status_q[4*ch + `CCT_STAT_OVF] & ~clrOvf);
          status_q[4*ch + `CCT_STAT_CMF] <= matchEv[ch] |
            (status_q[4*ch + `CCT_STAT_CMF] & ~clrCmf);
          // a read arms only flags seen as 1; arming drops once the flag drops
          armOvf_q[ch] <= status_q[4*ch + `CCT_STAT_OVF] & ~clrOvf &
            (armOvf_q[ch] | (rdSetup & selStat));
          armCmf_q[ch] <= status_q[4*ch + `CCT_STAT_CMF] & ~clrCmf &
            (armCmf_q[ch] | (rdSetup & selStat));
          if (wrStat) begin
            status_q[4*ch + `CCT_STAT_OVIE] <= wrByte[4*ch + `CCT_STAT_OVIE];
            status_q[4*ch + `CCT_STAT_CCLR] <= wrByte[4*ch + `CCT_STAT_CCLR];
          end
        end
      end
    end
  endgenerate

  // request bits: match always, overflow only when enabled
  wire hiReqSet = matchEv[1] | (ovfEv[1] & status_q[4 + `CCT_STAT_OVIE]);
  wire loReqSet = matchEv[0] | (ovfEv[0] & status_q[`CCT_STAT_OVIE]);

  // edge select, cpu enables and requests; a request set beats a clear
  always @(posedge ref_clk) begin
    if (rst) begin
      irqReg_q <= `CCT_RST_IRQ;
    end else begin
      if (wrEn & selIrq) begin
        irqReg_q[`CCT_IRQ_EDGE] <= wrByte[`CCT_IRQ_EDGE];
        irqReg_q[`CCT_IRQ_ENL] <= wrByte[`CCT_IRQ_ENL];
        irqReg_q[`CCT_IRQ_ENH] <= wrByte[`CCT_IRQ_ENH];
      end
      irqReg_q[`CCT_IRQ_REQH] <= hiReqSet | (irqReg_q[`CCT_IRQ_REQH] &
        ~(wrEn & selIrq & ~wrByte[`CCT_IRQ_REQH]));
      irqReg_q[`CCT_IRQ_REQL] <= loReqSet | (irqReg_q[`CCT_IRQ_REQL] &
        ~(wrEn & selIrq & ~wrByte[`CCT_IRQ_REQL]));
    end
  end

  // cpu interrupt lines only when the cpu enable is also set
  always @(posedge ref_clk) begin
    if (rst) begin
      hiIrqCpu <= 1'b0;
      loIrqCpu <= 1'b0;
    end else begin
      hiIrqCpu <= irqReg_q[`CCT_IRQ_REQH] & irqReg_q[`CCT_IRQ_ENH];
      loIrqCpu <= irqReg_q[`CCT_IRQ_REQL] & irqReg_q[`CCT_IRQ_ENL];
    end
  end

  // toggle outputs; a level write overrides a match in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      hiToggleOut <= 1'b0;
      loToggleOut <= 1'b0;
      eventPrev_q <= 1'b0;
    end else begin
      eventPrev_q <= eventIn;
      if (wrEn & selCtrl) begin
        hiToggleOut <= wrByte[`CCT_CTRL_HI_TOGGLE_LEVEL];
        loToggleOut <= wrByte[`CCT_CTRL_LO_TOGGLE_LEVEL];
      end else begin
        if (matchEv[1]) begin
          hiToggleOut <= ~hiToggleOut;
        end
        if (matchEv[0]) begin
          loToggleOut <= ~loToggleOut;
        end
      end
    end
  end

endmodule // cct_timer

// ### sim/cct_timer_asserts.sv
// port-level checker for the compare timer, bound to its top module
`timescale 1ns/1ps
`include "cct_timer_defs.vh"

module cct_timer_asserts (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CCT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire eventIn,
  input wire watchClk,
  input wire subClockMode,
  input wire hiToggleOut,
  input wire loToggleOut,
  input wire hiIrqCpu,
  input wire loIrqCpu
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // decode helpers; the irq register sits right after the compare bytes
  wire [15:0] idx = paddr[`CCT_ADDR_W-1:2];
  wire aligned = paddr[1:0] == 2'h0;
  wire mapped = aligned && ((idx >= `CCT_IDX_CTRL && idx <= `CCT_IDX_IRQ) || idx == `CCT_IDX_CKSTP);
  wire setup = psel && !penable;
  wire wrCtrl = psel && penable && pready && pwrite && aligned && idx == `CCT_IDX_CTRL;
  wire lvlHi = pwdata[`CCT_CTRL_HI_TOGGLE_LEVEL];
  wire lvlLo = pwdata[`CCT_CTRL_LO_TOGGLE_LEVEL];

  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  setup_answer_a: assert property (setup |=> pready)
    else $error("no answer in the cycle after setup");
  idle_quiet_a: assert property (!psel |=> !pready)
    else $error("pready without a selected transfer");
  bad_addr_err_a: assert property (setup && !mapped |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  good_addr_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  ctrl_reads_zero_a: assert property (setup && !pwrite && aligned && idx == `CCT_IDX_CTRL
    |=> prdata == 32'h0)
    else $error("control register readable");
  upper_bits_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  level_write_a: assert property (wrCtrl |-> ##[1:2]
    (hiToggleOut == $past(lvlHi) && loToggleOut == $past(lvlLo)))
    else $error("toggle outputs ignore the written levels");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=>
    !hiToggleOut && !loToggleOut && !hiIrqCpu && !loIrqCpu && !pready)
    else $error("outputs active after reset");

  // main scenarios reached
  cover property (wrCtrl);
  cover property (setup && !mapped);
  cover property ($rose(hiToggleOut));
  cover property ($rose(loIrqCpu));
endmodule // cct_timer_asserts

bind cct_timer cct_timer_asserts chk_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .eventIn(eventIn), .watchClk(watchClk),
  .subClockMode(subClockMode), .hiToggleOut(hiToggleOut), .loToggleOut(loToggleOut),
  .hiIrqCpu(hiIrqCpu), .loIrqCpu(loIrqCpu));

// ### sim/cct_pins_model.sv
// pin-side model: external event source and the watch oscillator
`timescale 1ns/1ps

module cct_pins_model (
  input wire ref_clk,
  input wire evtLvl,
  input wire watchOn,
  output logic eventIn,
  output logic watchClk
);
  logic [2:0] divCnt_q;

  initial begin
    eventIn = 1'b0;
    watchClk = 1'b0;
    divCnt_q = 3'h0;
  end

  // event pin follows the requested level; it feeds the lower counter only
  always @(posedge ref_clk) begin
    eventIn <= evtLvl;
  end

  // watch clock, ten reference cycles a period; held still when off so no stray ticks
  always @(posedge ref_clk) begin
    if (!watchOn) begin
      divCnt_q <= 3'h0;
    end else if (divCnt_q == 3'h4) begin
      divCnt_q <= 3'h0;
      watchClk <= !watchClk;
    end else begin
      divCnt_q <= divCnt_q + 3'h1;
    end
  end
endmodule // cct_pins_model

// ### sim/cascadable_compare_timer_tb.sv
// self-checking bench for the cascadable compare timer
`timescale 1ns/1ps
`include "cct_timer_defs.vh"

module cascadable_compare_timer_tb;
  logic ref_clk, rst, psel, penable, pwrite, subClockMode, evtLvl, watchOn, err;
  logic [`CCT_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, eventIn, watchClk, hiToggleOut, loToggleOut, hiIrqCpu, loIrqCpu;
  logic [7:0] rd, m;
  logic [2:0] code;
  logic sub;
  int bad_count = 0;
  int comparisons = 0;

  cct_timer dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eventIn(eventIn), .watchClk(watchClk), .subClockMode(subClockMode),
    .hiToggleOut(hiToggleOut), .loToggleOut(loToggleOut), .hiIrqCpu(hiIrqCpu),
    .loIrqCpu(loIrqCpu));
  cct_pins_model pins_u (.ref_clk(ref_clk), .evtLvl(evtLvl), .watchOn(watchOn),
    .eventIn(eventIn), .watchClk(watchClk));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the request is held until pready is seen high
  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rdx(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h0, rd}, {24'h0, exp});
  endtask

  // n full pulses on the event pin, slow enough for the edge detector
  task ev(input int n);
    repeat (2 * n) begin
      @(posedge ref_clk);
      evtLvl <= !evtLvl;
      repeat (3) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask

  // ticks expected over a window; low-power mode only lets watch/4 through
  function automatic int ticks(input logic [2:0] c, input logic s, input int cyc);
    int div;
    div = (c == `CCT_SEL_SYS32) ? 32 : (c == `CCT_SEL_SYS16) ? 16 : (c == `CCT_SEL_SYS4) ? 4 : 40;
    if (s && c != `CCT_SEL_WATCH4) return 0;
    return cyc / div;
  endfunction

  // prescaler phase leaves one tick of slack
  function automatic logic near(input logic [7:0] v, input int e);
    return (e == 0) ? (v == 8'h00) : (v + 1 >= e && v <= e + 1);
  endfunction

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    subClockMode = 1'b0;
    evtLvl = 1'b0;
    watchOn = 1'b0;
    void'($urandom(41759));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rdx(`CCT_IDX_CTRL, 8'h00);
    rdx(`CCT_IDX_CNTH, 8'h00);
    rdx(`CCT_IDX_CNTL, 8'h00);
    rdx(`CCT_IDX_CMPH, 8'hff);
    rdx(`CCT_IDX_CMPL, 8'hff);
    apb(1'b0, 16'hffbd, 8'h00);
    chk("unmapped error", err, 1'b1);
    $display("test reset values done");
    // 16-bit wrap through the holding latch, overflow enable off then on
    for (int ie = 0; ie < 2; ie++) begin
      wr(`CCT_IDX_IRQ, 8'h04);
      wr(`CCT_IDX_STAT, ie ? 8'h20 : 8'h00);
      wr(`CCT_IDX_CMPH, 8'h12);
      wr(`CCT_IDX_CMPL, 8'h34);
      wr(`CCT_IDX_CNTH, 8'hff);
      wr(`CCT_IDX_CNTL, 8'hfe);
      ev(3);
      rdx(`CCT_IDX_STAT, ie ? 8'ha0 : 8'h80);
      chk("hi irq", hiIrqCpu, ie[0]);
      rdx(`CCT_IDX_CNTH, 8'h00);
      rdx(`CCT_IDX_CNTL, 8'h01);
    end
    $display("test wide overflow done");
    // 16-bit match with clear; software cannot set flags
    wr(`CCT_IDX_STAT, 8'h30);
    rdx(`CCT_IDX_STAT, 8'h30);
    wr(`CCT_IDX_STAT, 8'hf0);
    rdx(`CCT_IDX_STAT, 8'h30);
    wr(`CCT_IDX_CMPH, 8'h00);
    wr(`CCT_IDX_CMPL, 8'h05);
    wr(`CCT_IDX_CNTH, 8'h00);
    wr(`CCT_IDX_CNTL, 8'h00);
    ev(6);
    rdx(`CCT_IDX_STAT, 8'h70);
    chk("hi toggle", hiToggleOut, 1'b1);
    rdx(`CCT_IDX_CNTH, 8'h00);
    rdx(`CCT_IDX_CNTL, 8'h00);
    $display("test wide match done");
    // 8-bit lower counter on events, random compare value
    m = 8'($urandom_range(2, 20));
    wr(`CCT_IDX_CTRL, 8'h70);
    wr(`CCT_IDX_STAT, 8'h01);
    wr(`CCT_IDX_IRQ, 8'h02);
    wr(`CCT_IDX_CMPL, m);
    wr(`CCT_IDX_CNTL, 8'h00);
    ev(m);
    chk("lo toggle", loToggleOut, 1'b1);
    chk("lo irq", loIrqCpu, 1'b1);
    ev(1);
    rdx(`CCT_IDX_CNTL, 8'h00);
    ev(m);
    rdx(`CCT_IDX_STAT, 8'h05);
    chk("lo toggle back", loToggleOut, 1'b0);
    rdx(`CCT_IDX_CNTH, 8'h00);
    wr(`CCT_IDX_STAT, 8'h02);
    wr(`CCT_IDX_IRQ, 8'h02);
    wr(`CCT_IDX_CNTL, 8'hfe);
    ev(2);
    rdx(`CCT_IDX_STAT, 8'h0a);
    chk("lo overflow irq", loIrqCpu, 1'b1);
    wr(`CCT_IDX_CTRL, 8'hf8);
    // the level lands at the commit edge; look one edge later
    @(posedge ref_clk);
    chk("hi level", hiToggleOut, 1'b1);
    chk("lo level", loToggleOut, 1'b1);
    $display("test byte mode events done");
    // falling edge selection, then module standby
    wr(`CCT_IDX_IRQ, 8'h03);
    wr(`CCT_IDX_CNTL, 8'h00);
    @(posedge ref_clk);
    evtLvl <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rdx(`CCT_IDX_CNTL, 8'h00);
    evtLvl <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rdx(`CCT_IDX_CNTL, 8'h01);
    wr(`CCT_IDX_CKSTP, 8'hfd);
    ev(3);
    rdx(`CCT_IDX_CNTL, 8'h01);
    wr(`CCT_IDX_CKSTP, 8'hff);
    $display("test edge and standby done");
    // internal clock sources, random low-power mode
    watchOn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      code = 3'h4 + 3'(k % 4);
      sub = 1'($urandom_range(0, 1));
      subClockMode <= sub;
      wr(`CCT_IDX_CTRL, {1'b0, code, 1'b0, code});
      wr(`CCT_IDX_CNTH, 8'h00);
      wr(`CCT_IDX_CNTL, 8'h00);
      repeat (800) @(posedge ref_clk);
      apb(1'b0, `CCT_IDX_CNTH, 8'h00);
      chk("hi ticks", near(rd, ticks(code, sub, 800)), 1'b1);
      apb(1'b0, `CCT_IDX_CNTL, 8'h00);
      chk("lo ticks", near(rd, ticks(code, sub, 800)), 1'b1);
    end
    // prohibited lower select code must give no ticks
    wr(`CCT_IDX_CTRL, 8'h71);
    wr(`CCT_IDX_CNTL, 8'h00);
    repeat (200) @(posedge ref_clk);
    rdx(`CCT_IDX_CNTL, 8'h00);
    $display("test clock sources done");
    wrap_up;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end
endmodule // cascadable_compare_timer_tb
